//--- sstx_pkg.sv
// constants, enumerations and timing counts for the sync-slot sensor frame transmitter
// assumes a single 125 MHz core clock and a sync pulse already recognised upstream

package sstx_pkg;

    // ---------------------------------------------------------------
    // clock and bit timing
    // ---------------------------------------------------------------
    localparam int CLK_HZ        = 125_000_000;
    localparam int CLK_NS        = 8;
    localparam int RATE_STD_BPS  = 125_000;
    localparam int RATE_FAST_BPS = 189_000;
    // fast half bit rounds down; standard half bit divides exactly
    localparam int HALF_STD_CYC  = CLK_HZ / (2 * RATE_STD_BPS);
    localparam int HALF_FAST_CYC = CLK_HZ / (2 * RATE_FAST_BPS);
    localparam logic [8:0] HALF_STD_LAST  = 9'(HALF_STD_CYC - 1);
    localparam logic [8:0] HALF_FAST_LAST = 9'(HALF_FAST_CYC - 1);
    // slot times count in microsecond ticks
    localparam int TICK_NS  = 1000;
    localparam int TICK_CYC = TICK_NS / CLK_NS;
    localparam logic [6:0] TICK_LAST = 7'(TICK_CYC - 1);

    // ---------------------------------------------------------------
    // frame layout
    // ---------------------------------------------------------------
    localparam int NUM_SLOTS  = 3;
    localparam int TIME_W     = 16;
    localparam int START_BITS = 2;
    localparam int CTL_BITS   = 3;
    localparam int CRC_BITS   = 3;
    localparam int QUAD_BITS  = 2;
    localparam int RAW_W      = 16;
    localparam int DATA_MAX   = 24;
    localparam int FRAME_MAX  = 33;
    localparam int LEN_W      = 6;
    localparam logic [4:0] SIZE_MIN = 5'h09;
    localparam logic [4:0] SIZE_MAX = 5'h10;
    localparam logic [4:0] PAD_MAX  = 5'h18;
    localparam logic [2:0] CRC_SEED = 3'h7;
    localparam logic [2:0] CRC_POLY = 3'h3;
    localparam logic [2:0] CTLC_POS = 3'h0;
    localparam logic [2:0] CTLC_SPD = 3'h1;

    typedef enum logic [1:0] {
        SRC_POS   = 2'h0,
        SRC_QUAD  = 2'h1,
        SRC_SPEED = 2'h2
    } sstx_src_t;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_FIRST  = 3'b010,
        ST_SECOND = 3'b100
    } sstx_state_t;

endpackage : sstx_pkg

//--- sstx_pair_buf.sv
// frame buffer between the frame builder and the serialiser; counts two entries, but a push into the second leaves tail_reg unwritten
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none

module sstx_pair_buf
    import sstx_pkg::*;
#(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         i_core_clk,
    input  wire logic         i_srst,
    // filling side
    input  wire logic         i_s_valid,
    output logic              o_s_ready,
    input  wire logic [W-1:0] i_s_data,
    // draining side
    output logic              o_m_valid,
    input  wire logic         i_m_ready,
    output logic [W-1:0]      o_m_data
);

    logic [W-1:0] head_reg;
    logic [W-1:0] tail_reg;
    logic [1:0]   cnt_reg;
    wire          push = i_s_valid && o_s_ready;
    wire          pop  = o_m_valid && i_m_ready;

    assign o_s_ready = (cnt_reg != 2'h2);
    assign o_m_valid = (cnt_reg != 2'h0);
    assign o_m_data  = head_reg;

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            cnt_reg <= 2'h0;
        end else begin
            cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
        end
    end

    // head refills from tail on pop; a push into an emptying head goes straight there
    always_ff @(posedge i_core_clk) begin
        if (pop) begin
            head_reg <= (push && cnt_reg == 2'h1) ? i_s_data : tail_reg;
        end else if (push && cnt_reg == 2'h0) begin
            head_reg <= i_s_data;
        end
        if (push && (cnt_reg == 2'h2 - {1'b0, pop})) begin
            tail_reg <= i_s_data;
        end
    end

endmodule : sstx_pair_buf

`default_nettype wire

//--- sstx_frame_tx.sv
// slot timing, frame building and manchester serialiser for the sensor link
// assumes a recognised sync pulse as a one-cycle strobe and live sensor data inputs
`timescale 1ns/1ps
`default_nettype none

module sstx_frame_tx
    import sstx_pkg::*;
#(
    parameter int SAMP_US = 500
) (
    // clock and reset
    input  wire logic                        i_core_clk,
    input  wire logic                        i_srst,
    // sync from the control unit
    input  wire logic                        i_sync_pulse,
    // slot configuration
    input  wire logic [NUM_SLOTS-1:0]        i_slot_en,
    input  wire logic [NUM_SLOTS*TIME_W-1:0] i_slot_start_time,
    input  wire logic [NUM_SLOTS*2-1:0]      i_slot_src,
    // frame configuration
    input  wire logic                        i_bitrate_fast,
    input  wire logic                        i_ctl_en,
    input  wire logic                        i_ctl_src_code,
    input  wire logic                        i_status_en,
    input  wire logic                        i_crc_sel,
    input  wire logic [4:0]                  i_pos_size,
    input  wire logic [4:0]                  i_spd_size,
    input  wire logic [4:0]                  i_pad_size,
    input  wire logic                        i_samp_sync_en,
    // sensor data
    input  wire logic [RAW_W-1:0]            i_pos_data,
    input  wire logic [QUAD_BITS-1:0]        i_quadrant,
    input  wire logic [RAW_W-1:0]            i_speed_data,
    input  wire logic                        i_frame_error_flag,
    // link and status
    output logic                             o_mod_high,
    output logic                             o_samp_strobe,
    output logic                             o_frame_done,
    output logic                             o_busy,
    output logic [NUM_SLOTS-1:0]             o_slot_pending
);

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_srst);

    // ---------------------------------------------------------------
    // microsecond tick
    // ---------------------------------------------------------------
    logic [6:0] tick_cnt_reg;
    wire        tick = (tick_cnt_reg == TICK_LAST);

    always_ff @(posedge i_core_clk) begin
        if (i_srst || i_sync_pulse || tick) begin
            tick_cnt_reg <= 7'h00;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 7'h01;
        end
    end

    // ---------------------------------------------------------------
    // slot timer
    // ---------------------------------------------------------------
    // start times are frozen at the sync so a mid-cycle rewrite cannot split a window
    logic [NUM_SLOTS*TIME_W-1:0] slot_start_time_reg;
    logic [TIME_W-1:0]           time_reg;
    logic [NUM_SLOTS-1:0]        armed_reg;
    logic [NUM_SLOTS-1:0]        pend_reg;
    logic [NUM_SLOTS-1:0]        hit;
    logic [NUM_SLOTS-1:0]        take;
    logic [1:0]                  sel;
    wire                         time_sat = (time_reg == {TIME_W{1'b1}});

    always_comb begin
        for (int s = 0; s < NUM_SLOTS; s++) begin
            hit[s] = armed_reg[s] && tick
                     && (time_reg == slot_start_time_reg[s*TIME_W +: TIME_W]);
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            time_reg  <= '0;
            armed_reg <= '0;
        end else if (i_sync_pulse) begin
            time_reg            <= '0;
            armed_reg           <= i_slot_en;
            slot_start_time_reg <= i_slot_start_time;
        end else begin
            if (tick && !time_sat) begin
                time_reg <= time_reg + 16'h0001;
            end
            armed_reg <= armed_reg & ~hit;
        end
    end

    // a slot that falls due in the cycle its previous frame is taken is set again, never lost
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            pend_reg <= '0;
        end else begin
            pend_reg <= (pend_reg & ~take) | hit;
        end
    end

    // lowest pending slot goes first
    assign sel = pend_reg[0] ? 2'h0 : (pend_reg[1] ? 2'h1 : 2'h2);
    assign o_slot_pending = pend_reg;

    // ---------------------------------------------------------------
    // sample strobe
    // ---------------------------------------------------------------
    logic [TIME_W-1:0] samp_us_reg;
    logic              samp_reg;
    wire               samp_free = tick && (samp_us_reg == 16'(SAMP_US - 1));

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            samp_us_reg <= '0;
            samp_reg    <= 1'b0;
        end else begin
            if (samp_free) begin
                samp_us_reg <= '0;
            end else if (tick) begin
                samp_us_reg <= samp_us_reg + 16'h0001;
            end
            samp_reg <= i_samp_sync_en ? i_sync_pulse : samp_free;
        end
    end

    assign o_samp_strobe = samp_reg;

    // ---------------------------------------------------------------
    // frame builder
    // ---------------------------------------------------------------
    logic [2:0]           roll_reg;
    sstx_src_t            src;
    logic [4:0]           sig_sz;
    logic [4:0]           fld_sz;
    logic [4:0]           pad_sz;
    logic [RAW_W-1:0]     raw;
    logic [DATA_MAX-1:0]  dval;
    logic [2:0]           ctl_val;
    logic [FRAME_MAX-1:0] frm_bits;
    logic [LEN_W-1:0]     frm_n;
    logic [2:0]           crc;
    logic                 fb;
    logic                 push;
    logic                 in_ready;

    function automatic logic [4:0] clamp_size(input logic [4:0] sz);
        clamp_size = (sz < SIZE_MIN) ? SIZE_MIN : ((sz > SIZE_MAX) ? SIZE_MAX : sz);
    endfunction : clamp_size

    assign src     = sstx_src_t'(i_slot_src[sel*2 +: 2]);
    assign raw     = (src == SRC_SPEED) ? i_speed_data : i_pos_data;
    assign ctl_val = i_ctl_src_code ? ((src == SRC_SPEED) ? CTLC_SPD : CTLC_POS) : roll_reg;
    assign pad_sz  = (i_pad_size > PAD_MAX) ? PAD_MAX : i_pad_size;

    always_comb begin
        sig_sz = clamp_size((src == SRC_SPEED) ? i_spd_size : i_pos_size);
        dval   = '0;
        for (int k = 0; k < RAW_W; k++) begin
            if (5'(k) < sig_sz) begin
                dval[k] = raw[k];
            end
        end
        if (src == SRC_QUAD) begin
            dval[sig_sz]         = i_quadrant[0];
            dval[sig_sz + 5'h01] = i_quadrant[1];
            sig_sz               = sig_sz + 5'(QUAD_BITS);
        end
        fld_sz = (pad_sz > sig_sz) ? pad_sz : sig_sz;
    end

    // bit 0 of frm_bits leaves the pin first
    always_comb begin
        frm_bits = '0;
        frm_n    = LEN_W'(START_BITS);
        crc      = CRC_SEED;
        fb       = 1'b0;
        if (i_ctl_en) begin
            for (int k = 0; k < CTL_BITS; k++) begin
                frm_bits[frm_n + LEN_W'(k)] = ctl_val[k];
            end
            frm_n = frm_n + LEN_W'(CTL_BITS);
        end
        if (i_status_en) begin
            frm_bits[frm_n] = i_frame_error_flag;
            frm_n           = frm_n + 6'h01;
        end
        for (int k = 0; k < DATA_MAX; k++) begin
            if (5'(k) < fld_sz) begin
                frm_bits[frm_n + LEN_W'(k)] = dval[k];
            end
        end
        frm_n = frm_n + {1'b0, fld_sz};
        // checksum covers the payload only, never the start bits
        for (int k = START_BITS; k < FRAME_MAX; k++) begin
            if (LEN_W'(k) < frm_n) begin
                fb  = crc[2] ^ frm_bits[k];
                crc = {crc[1:0], 1'b0} ^ (fb ? CRC_POLY : 3'h0);
            end
        end
        if (i_crc_sel) begin
            frm_bits[frm_n]         = crc[2];
            frm_bits[frm_n + 6'h01] = crc[1];
            frm_bits[frm_n + 6'h02] = crc[0];
            frm_n                   = frm_n + LEN_W'(CRC_BITS);
        end else begin
            frm_bits[frm_n] = ^frm_bits;
            frm_n           = frm_n + 6'h01;
        end
    end

    // a full buffer holds the slot pending, so back-pressure reaches the slot timer
    assign push = (|pend_reg) && in_ready;
    assign take = push ? (NUM_SLOTS'(1) << sel) : '0;

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            roll_reg <= 3'h0;
        end else if (push) begin
            roll_reg <= roll_reg + 3'h1;
        end
    end

    // ---------------------------------------------------------------
    // buffer
    // ---------------------------------------------------------------
    logic                         out_valid;
    logic                         out_ready;
    logic [FRAME_MAX+LEN_W-1:0]   out_data;

    sstx_pair_buf #(
        .W (FRAME_MAX + LEN_W)
    ) u_buf (
        .i_core_clk (i_core_clk),
        .i_srst     (i_srst),
        .i_s_valid  (|pend_reg),
        .o_s_ready  (in_ready),
        .i_s_data   ({frm_n, frm_bits}),
        .o_m_valid  (out_valid),
        .i_m_ready  (out_ready),
        .o_m_data   (out_data)
    );

    // ---------------------------------------------------------------
    // manchester serialiser
    // ---------------------------------------------------------------
    sstx_state_t          st_reg;
    sstx_state_t          st_next;
    logic [FRAME_MAX-1:0] shift_reg;
    logic [LEN_W-1:0]     left_reg;
    logic [8:0]           half_reg;
    logic                 mod_reg;
    logic                 mod_next;
    logic                 done_reg;
    wire  [8:0]           half_last = i_bitrate_fast ? HALF_FAST_LAST : HALF_STD_LAST;
    wire                  half_end  = (half_reg == half_last);
    wire                  last_bit  = (left_reg == 6'h01);

    assign out_ready = (st_reg == ST_IDLE);

    // first half carries the bit, second its inverse: rising mid-bit edge is zero
    always_comb begin
        st_next  = st_reg;
        mod_next = mod_reg;
        case (st_reg)
            ST_IDLE: begin
                mod_next = 1'b0;
                if (out_valid) begin
                    st_next  = ST_FIRST;
                    mod_next = out_data[0];
                end
            end
            ST_FIRST: begin
                if (half_end) begin
                    st_next  = ST_SECOND;
                    mod_next = !shift_reg[0];
                end
            end
            ST_SECOND: begin
                if (half_end) begin
                    st_next  = last_bit ? ST_IDLE : ST_FIRST;
                    mod_next = last_bit ? 1'b0 : shift_reg[1];
                end
            end
            default: begin
                st_next  = ST_IDLE;
                mod_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            st_reg   <= ST_IDLE;
            mod_reg  <= 1'b0;
            done_reg <= 1'b0;
            half_reg <= 9'h000;
        end else begin
            st_reg   <= st_next;
            mod_reg  <= mod_next;
            done_reg <= (st_reg == ST_SECOND) && half_end && last_bit;
            half_reg <= (st_reg == ST_IDLE || half_end) ? 9'h000 : half_reg + 9'h001;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (st_reg == ST_IDLE && out_valid) begin
            shift_reg <= out_data[FRAME_MAX-1:0];
            left_reg  <= out_data[FRAME_MAX +: LEN_W];
        end else if (st_reg == ST_SECOND && half_end) begin
            shift_reg <= shift_reg >> 1;
            left_reg  <= left_reg - 6'h01;
        end
    end

    assign o_mod_high   = mod_reg;
    assign o_frame_done = done_reg;
    assign o_busy       = (st_reg != ST_IDLE) || out_valid;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    property p_start_low;
        (st_reg == ST_IDLE && out_valid) |-> (out_data[1:0] == 2'b00) ##1 !o_mod_high;
    endproperty
    a_start_low: assert property (p_start_low) else $error("start bit not zero");
    property p_manch;
        (st_reg == ST_SECOND) |-> (o_mod_high == !shift_reg[0]);
    endproperty
    a_manch: assert property (p_manch) else $error("second half not inverted");
    property p_half_len;
        $rose(st_reg == ST_SECOND) && !i_bitrate_fast |-> $past(st_reg == ST_FIRST, HALF_STD_CYC);
    endproperty
    a_half_len: assert property (p_half_len) else $error("half bit length wrong");
    property p_slot_due;
        (hit[0] && !i_sync_pulse) |=> pend_reg[0] && !armed_reg[0];
    endproperty
    a_slot_due: assert property (p_slot_due) else $error("due slot not pending");
    property p_samp;
        (i_samp_sync_en && i_sync_pulse) |=> o_samp_strobe;
    endproperty
    a_samp: assert property (p_samp) else $error("sample not aligned to sync");
    property p_roll;
        (push && i_ctl_en && !i_ctl_src_code) |-> frm_bits[4:2] == roll_reg ##1 roll_reg == $past(roll_reg) + 3'h1;
    endproperty
    a_roll: assert property (p_roll) else $error("rolling counter wrong");
    property p_len;
        (push && i_crc_sel && !i_ctl_en && !i_status_en) |-> frm_n == LEN_W'(START_BITS + CRC_BITS) + {1'b0, fld_sz};
    endproperty
    a_len: assert property (p_len) else $error("frame length wrong");
    property p_lsb;
        (push && !i_ctl_en && !i_status_en && src == SRC_POS) |-> frm_bits[2] == i_pos_data[0];
    endproperty
    a_lsb: assert property (p_lsb) else $error("data not lsb first");
    property p_pad;
        (push && pad_sz > sig_sz) |-> (dval >> sig_sz) == '0;
    endproperty
    a_pad: assert property (p_pad) else $error("padding not zero");

endmodule : sstx_frame_tx

`default_nettype wire

//--- sstx_ecu_model.sv
// control unit model: sync generator and manchester receiver of the current link
// assumes the bench raises i_sync_req once for each sync pulse it wants sent
`timescale 1ns/1ps
`default_nettype none

module sstx_ecu_model
    import sstx_pkg::*;
(
    // clock and bench control
    input  wire logic        i_core_clk,
    input  wire logic        i_sync_req,
    input  wire logic        i_fast,
    // link
    input  wire logic        i_mod_high,
    output var  logic        o_sync_pulse,
    // received frames
    output var  logic [63:0] o_rx_bits,
    output var  int          o_rx_len,
    output var  int          o_rx_rise,
    output var  int          o_rx_count
);
    logic req_d = 1'b0;
    int   since = 0;
    int   half;
    logic a;

    initial begin
        o_sync_pulse = 1'b0;
        o_rx_count   = 0;
    end

    // one pulse per request; spacing of requests is chosen by the bench
    always @(posedge i_core_clk) begin
        req_d        <= i_sync_req;
        o_sync_pulse <= i_sync_req && !req_d;
        since        <= (i_sync_req && !req_d) ? 0 : since + 1;
    end

    // bit 0 is a zero, so its mid-bit rise is the first visible edge;
    // two equal halves mean the line went idle, which ends the frame
    initial forever begin
        @(posedge i_core_clk);
        if (i_mod_high === 1'b1) begin
            half      = i_fast ? HALF_FAST_CYC : HALF_STD_CYC;
            o_rx_rise = since;
            o_rx_bits = '0;
            o_rx_len  = 1;
            repeat (half / 2) @(posedge i_core_clk);
            forever begin
                repeat (half) @(posedge i_core_clk);
                a = i_mod_high;
                repeat (half) @(posedge i_core_clk);
                if (a === i_mod_high) break;
                o_rx_bits[o_rx_len] = a;
                o_rx_len++;
            end
            o_rx_count++;
        end
    end
endmodule : sstx_ecu_model
`default_nettype wire

//--- sstx_frame_tx_tb.sv
// self-checking bench for the frame transmitter against a bit-level frame model
// assumes the control unit model decodes the link and counts frames
`timescale 1ns/1ps
`default_nettype none

module sstx_frame_tx_tb;
    import sstx_pkg::*;
    logic clk = 0, srst = 1, sreq = 0, sync, fast = 0, ctl = 0, csrc = 0, sten = 0, crcs = 0;
    logic ssen = 0, err = 0, mod, samp, done, busy;
    logic [2:0] en = 0, pend;
    logic [47:0] st = 0;
    logic [5:0] src = 0;
    logic [4:0] psz = 9, ssz = 9, pad = 0;
    logic [15:0] pos = 0, spd = 0;
    logic [1:0] quad = 0;
    logic [63:0] rx_bits, exp_bits[$];
    int rx_len, rx_rise, rx_cnt, exp_len[$], exp_t[$], pushed = 0, mismatches = 0, comparisons = 0;

    int done_cnt = 0;

    always #4 clk = ~clk;

    always @(posedge clk) if (done === 1'b1) done_cnt++;

    sstx_frame_tx #(.SAMP_US(4)) i_dut (.i_core_clk(clk), .i_srst(srst), .i_sync_pulse(sync),
        .i_slot_en(en), .i_slot_start_time(st), .i_slot_src(src), .i_bitrate_fast(fast),
        .i_ctl_en(ctl), .i_ctl_src_code(csrc), .i_status_en(sten), .i_crc_sel(crcs),
        .i_pos_size(psz), .i_spd_size(ssz), .i_pad_size(pad), .i_samp_sync_en(ssen),
        .i_pos_data(pos), .i_quadrant(quad), .i_speed_data(spd), .i_frame_error_flag(err),
        .o_mod_high(mod), .o_samp_strobe(samp), .o_frame_done(done), .o_busy(busy),
        .o_slot_pending(pend));

    sstx_ecu_model i_ecu (.i_core_clk(clk), .i_sync_req(sreq), .i_fast(fast), .i_mod_high(mod),
        .o_sync_pulse(sync), .o_rx_bits(rx_bits), .o_rx_len(rx_len), .o_rx_rise(rx_rise),
        .o_rx_count(rx_cnt));

    // ---------------------------------------------------------------
    // frame model
    // ---------------------------------------------------------------
    // the rolling counter advances for every frame, used or not
    function automatic void add_frame(input int t, input int s);
        logic [63:0] b = '0;
        logic [2:0] crc = CRC_SEED;
        logic [2:0] cnt = pushed[2:0];
        logic [15:0] d = (s == 2) ? spd : pos;
        int w = (s == 2) ? int'(ssz) : int'(psz);
        int n = 2;
        if (w < int'(SIZE_MIN)) w = int'(SIZE_MIN);
        if (w > int'(SIZE_MAX)) w = int'(SIZE_MAX);
        pushed++;
        if (ctl) for (int i = 0; i < 3; i++) b[n++] = csrc ? (i == 0 && s == 2) : cnt[i];
        if (sten) b[n++] = err;
        for (int i = 0; i < w; i++) b[n++] = d[i];
        if (s == 1) begin
            b[n++] = quad[0];
            b[n++] = quad[1];
            w += 2;
        end
        for (; w < int'(pad); w++) b[n++] = 1'b0;
        if (crcs) begin
            for (int i = 2; i < n; i++) crc = {crc[1:0], 1'b0} ^ ((crc[2] ^ b[i]) ? CRC_POLY : 3'h0);
            for (int i = 2; i >= 0; i--) b[n++] = crc[i];
        end else b[n++] = ^b;
        exp_bits.push_back(b);
        exp_len.push_back(n);
        exp_t.push_back(t);
    endfunction : add_frame

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    // ---------------------------------------------------------------
    // one sync and its frames
    // ---------------------------------------------------------------
    task automatic fire(input int nfr, input string name);
        int e, base;
        logic seen_samp = 0;
        base = rx_cnt;
        @(posedge clk); #1 sreq = 1;
        @(posedge clk); #1 sreq = 0;
        repeat (4) begin
            @(posedge clk); #1 seen_samp |= samp;
        end
        if (ssen) check("sample strobe", seen_samp, 1);
        for (int k = 1; k <= nfr; k++) begin
            for (int c = 0; c < 40000 && rx_cnt < base + k; c++) @(posedge clk);
            #1 check("frame count", rx_cnt, base + k);
            e = 125 * exp_t[0] + 130 + (fast ? HALF_FAST_CYC : HALF_STD_CYC);
            check("start time", rx_rise >= e - 3 && rx_rise <= e + 3, 1);
            check("frame length", rx_len, exp_len.pop_front());
            check("frame bits", rx_bits, exp_bits.pop_front());
            void'(exp_t.pop_front());
        end
        $display("test %s done", name);
    endtask : fire

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (90000) @(posedge clk);
        mismatches++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(53));
        repeat (6) @(posedge clk);
        #1 srst = 0;
        // plain position, parity, standard rate, slot 0 at time zero
        pos = 16'($urandom);
        en = 3'b001;
        add_frame(0, 0);
        fire(1, "plain");
        // fast rate, quadrant with padding then speed, counter, status, crc; slot 2 disabled
        {fast, ctl, sten, crcs, err, psz, ssz, pad} = {5'h1f, 5'h0c, 5'h10, 5'h10};
        {pos, spd, quad} = 34'($urandom) ^ {$urandom, 2'h0};
        {en, st, src} = {3'b011, 16'd10, 16'd150, 16'd3, 6'h09};
        add_frame(3, 1);
        add_frame(150, 2);
        fire(2, "quadrant and speed");
        // source code in frame control, speed on slot 2 only, sample strobe tied to sync
        {fast, csrc, sten, crcs, ssen, ssz, pad} = {5'h0b, 5'h1f, 5'h00};
        spd = 16'($urandom);
        {en, st, src} = {3'b100, 16'd1, 16'd0, 16'd0, 6'h20};
        add_frame(1, 2);
        fire(1, "source code");
        repeat (2000) @(posedge clk);
        #1 check("busy idle", busy, 0);
        check("nothing pending", pend, 0);
        check("no extra frame", rx_cnt, 4);
        check("frame done count", done_cnt, 4);
        tally_and_finish();
    end
endmodule : sstx_frame_tx_tb
`default_nettype wire
